// *** src/rtc_pkg.sv ***
// package: register map, bus identifiers, link states and carrier types of the rtc core
package rtc_pkg;
  // calendar and status registers
  localparam logic [7:0] OFS_SECONDS = 8'h00;
  localparam logic [7:0] OFS_MINUTES = 8'h01;
  localparam logic [7:0] OFS_HOURS = 8'h02;
  localparam logic [7:0] OFS_DATE = 8'h03;
  localparam logic [7:0] OFS_MONTH = 8'h04;
  localparam logic [7:0] OFS_YEAR = 8'h05;
  localparam logic [7:0] OFS_WEEKDAY = 8'h06;
  localparam logic [7:0] OFS_STATUS = 8'h07;
  // compensation registers
  localparam logic [7:0] OFS_INITIAL_TRIM = 8'h0b;
  localparam logic [7:0] OFS_CRYSTAL_COEF_COLD = 8'h0c;
  localparam logic [7:0] OFS_COMP_CONTROL_TRIM = 8'h0d;
  localparam logic [7:0] OFS_ANALOG_TRIM_VALUE = 8'h0e;
  localparam logic [7:0] OFS_DIGITAL_TRIM_VALUE = 8'h0f;
  // daylight saving registers
  localparam logic [7:0] OFS_DST_FWD_MONTH = 8'h15;
  localparam logic [7:0] OFS_DST_FWD_WEEKDAY = 8'h16;
  localparam logic [7:0] OFS_DST_FWD_DATE = 8'h17;
  localparam logic [7:0] OFS_DST_FWD_HOUR = 8'h18;
  localparam logic [7:0] OFS_DST_REV_MONTH = 8'h19;
  localparam logic [7:0] OFS_DST_REV_WEEKDAY = 8'h1a;
  localparam logic [7:0] OFS_DST_REV_DATE = 8'h1b;
  localparam logic [7:0] OFS_DST_REV_HOUR = 8'h1c;
  // pointer limits and bus identifiers
  localparam logic [7:0] RTC_LAST_PTR = 8'h2f;
  localparam logic [7:0] SRAM_LAST_PTR = 8'h7f;
  localparam logic [6:0] ID_RTC = 7'h6f;
  localparam logic [6:0] ID_SRAM = 7'h57;
  // field positions and the last-week code
  localparam int TSE_BIT = 7;
  localparam int BMODE_HI = 6;
  localparam int BMODE_LO = 5;
  localparam int TRIM_MSB = 4;
  localparam int DST_ENABLE_BIT = 7;
  localparam int WEEKDAY_SEL_BIT = 6;
  localparam int WEEK_MSB = 5;
  localparam int WEEK_LSB = 3;
  localparam int DAY_MSB = 2;
  localparam int STATUS_DST_BIT = 5;
  localparam logic [2:0] LAST_WEEK = 3'h7;
  // calendar limits in bcd
  localparam logic [7:0] MINSEC_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] DOW_LAST = 8'h06;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // compensation intervals in seconds
  localparam logic [7:0] COMP_PERIOD_S = 8'd60;
  localparam logic [7:0] BAT_PERIOD_1_S = 8'd60;
  localparam logic [7:0] BAT_PERIOD_2_S = 8'd120;
  localparam logic [7:0] BAT_PERIOD_3_S = 8'd240;
  // timebase
  localparam int OSC_HZ_DEFAULT = 32768;

  typedef enum logic [3:0] {
    LINK_IDLE, DEV_ID, DEV_ACK, WORD_ADDR, ADDR_ACK,
    WR_DATA, WR_ACK, RD_DATA, RD_ACK, WAIT_STOP
  } linkState_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cPins_t;

  typedef struct packed {
    logic sdaOut;
    logic sdaOe;
  } sdaDrive_t;
endpackage : rtc_pkg

// *** src/rtc_core.sv ***
// rtc core: serial read/write path, temperature compensation control and daylight saving
//////////////////////////////////////////////////////////////////////////////////////////
module rtc_core #(
  parameter int OSC_HZ = rtc_pkg::OSC_HZ_DEFAULT,
  parameter logic [7:0] FACTORY_INITIAL_TRIM = 8'h10,
  parameter logic [7:0] FACTORY_CRYSTAL_COEF = 8'h40,
  parameter logic [4:0] FACTORY_TRIM = 5'h08
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkOsc,
  input wire rtc_pkg::i2cPins_t i2cIn,
  input wire logic vddPresent,
  input wire logic [9:0] tempCode,
  output rtc_pkg::sdaDrive_t sdaDrv,
  output logic daylightForwardDone,
  output logic compCycle
);
  import rtc_pkg::*;

  // elaboration check on the timebase divider
  if (OSC_HZ < 2 || OSC_HZ > 65536) begin : gen_osc_check
    $error("OSC_HZ out of range");
  end

  localparam logic [15:0] OSC_LAST = 16'(OSC_HZ - 1);

  typedef struct packed {
    logic [15:0] cnt;
    logic secToggle;
  } oscState_t;

  typedef struct packed {
    i2cPins_t pinMeta;
    i2cPins_t pinSync;
    i2cPins_t pinPrev;
    logic vddMeta;
    logic vddSync;
    logic tickMeta;
    logic tickSync;
    logic tickPrev;
    linkState_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] txByte;
    logic useSram;
    logic [7:0] ptr;
    logic masterAck;
    sdaDrive_t drv;
    logic [47:0][7:0] regs;
    logic [127:0][7:0] sram;
    logic recallDone;
    logic [9:0] lastTemp;
    logic [7:0] compSecs;
    logic compPulse;
  } coreState_t;

  oscState_t oscReg, oscNext;
  coreState_t r, n;

  //////////////////////////////////////////////////////////////////////////////////////////
  // helper functions

  // bcd increment with wrap to a given first value
  function automatic logic [7:0] bcdInc(input logic [7:0] v, input logic [7:0] lim,
                                         input logic [7:0] first);
    if (v >= lim) return first;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  // bcd hour decrement with wrap below midnight
  function automatic logic [7:0] hourDec(input logic [7:0] v);
    if (v == BCD_ZERO) return HOUR_LAST;
    if (v[3:0] == 4'h0) return {v[7:4] - 4'h1, 4'h9};
    return {v[7:4], v[3:0] - 4'h1};
  endfunction : hourDec

  function automatic logic [6:0] bcdToBin(input logic [7:0] v);
    return 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
  endfunction : bcdToBin

  // days in the current month, leap years every fourth year
  function automatic logic [6:0] monthDays(input logic [7:0] month, input logic [7:0] year);
    logic [6:0] m;
    m = bcdToBin(month);
    if (m == 7'd2) return (bcdToBin(year) % 7'd4 == 7'd0) ? 7'd29 : 7'd28;
    if (m == 7'd4 || m == 7'd6 || m == 7'd9 || m == 7'd11) return 7'd30;
    return 7'd31;
  endfunction : monthDays

  // match of one daylight point against the running calendar
  function automatic logic dstMatch(input logic [47:0][7:0] rg, input logic [7:0] base);
    logic [7:0] monReg, wdReg, dateReg, hourReg;
    logic [6:0] dateBin, mdays;
    logic [2:0] week;
    logic dayOk;
    monReg = rg[base[5:0]];
    wdReg = rg[6'(base + 8'h1)];
    dateReg = rg[6'(base + 8'h2)];
    hourReg = rg[6'(base + 8'h3)];
    dateBin = bcdToBin(rg[OFS_DATE[5:0]]);
    mdays = monthDays(rg[OFS_MONTH[5:0]], rg[OFS_YEAR[5:0]]);
    week = wdReg[WEEK_MSB:WEEK_LSB];
    if (wdReg[WEEKDAY_SEL_BIT]) begin
      dayOk = wdReg[DAY_MSB:0] == rg[OFS_WEEKDAY[5:0]][DAY_MSB:0];
      if (week == LAST_WEEK) begin
        dayOk = dayOk && (dateBin + 7'd7 > mdays);
      end else begin
        dayOk = dayOk && (3'((dateBin - 7'd1) / 7'd7) + 3'h1 == week);
      end
    end else begin
      dayOk = dateReg == rg[OFS_DATE[5:0]];
    end
    // month without enable bit, hour as plain 24-hour bcd
    return monReg[4:0] == rg[OFS_MONTH[5:0]][4:0] && dayOk
           && hourReg == rg[OFS_HOURS[5:0]];
  endfunction : dstMatch

  // pointer step with wrap at the end of the selected space
  function automatic logic [7:0] nextPtr(input logic [7:0] p, input logic sram);
    if (sram) return (p >= SRAM_LAST_PTR) ? 8'h00 : p + 8'h01;
    return (p >= RTC_LAST_PTR) ? 8'h00 : p + 8'h01;
  endfunction : nextPtr

  //////////////////////////////////////////////////////////////////////////////////////////
  // timebase domain: one toggle per second

  always_comb begin
    oscNext = oscReg;
    if (oscReg.cnt >= OSC_LAST) begin
      oscNext.cnt = 16'h0000;
      oscNext.secToggle = ~oscReg.secToggle;
    end else begin
      oscNext.cnt = oscReg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clkOsc or negedge rst_b) begin
    if (!rst_b) begin
      oscReg <= '0;
    end else begin
      oscReg <= oscNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // system domain: link, calendar, compensation

  always_comb begin
    logic sclRise, sclFall, startSeen, stopSeen, secTick, compReq, hourTurn;
    logic [7:0] wrData, bPeriod;
    n = r;
    sclRise = 1'b0;
    sclFall = 1'b0;
    startSeen = 1'b0;
    stopSeen = 1'b0;
    secTick = 1'b0;
    compReq = 1'b0;
    hourTurn = 1'b0;
    wrData = 8'h00;
    bPeriod = 8'h00;

    // synchronisers and edge detection on the settled copies
    n.pinMeta = i2cIn;
    n.pinSync = r.pinMeta;
    n.pinPrev = r.pinSync;
    n.vddMeta = vddPresent;
    n.vddSync = r.vddMeta;
    n.tickMeta = oscReg.secToggle;
    n.tickSync = r.tickMeta;
    n.tickPrev = r.tickSync;
    sclRise = r.pinSync.scl && !r.pinPrev.scl;
    sclFall = !r.pinSync.scl && r.pinPrev.scl;
    startSeen = r.pinSync.scl && r.pinPrev.scl && r.pinPrev.sda && !r.pinSync.sda;
    stopSeen = r.pinSync.scl && r.pinPrev.scl && !r.pinPrev.sda && r.pinSync.sda;
    secTick = r.tickSync ^ r.tickPrev;
    n.compPulse = 1'b0;
    n.drv.sdaOut = 1'b0;

    // calendar advance on each second
    if (secTick) begin
      n.regs[OFS_SECONDS[5:0]] = bcdInc(r.regs[OFS_SECONDS[5:0]], MINSEC_LAST, BCD_ZERO);
      if (r.regs[OFS_SECONDS[5:0]] == MINSEC_LAST) begin
        n.regs[OFS_MINUTES[5:0]] = bcdInc(r.regs[OFS_MINUTES[5:0]], MINSEC_LAST, BCD_ZERO);
        if (r.regs[OFS_MINUTES[5:0]] == MINSEC_LAST) begin
          hourTurn = 1'b1;
          n.regs[OFS_HOURS[5:0]] = bcdInc(r.regs[OFS_HOURS[5:0]], HOUR_LAST, BCD_ZERO);
          if (r.regs[OFS_HOURS[5:0]] == HOUR_LAST) begin
            n.regs[OFS_WEEKDAY[5:0]] = bcdInc(r.regs[OFS_WEEKDAY[5:0]], DOW_LAST, BCD_ZERO);
            if (bcdToBin(r.regs[OFS_DATE[5:0]])
                >= monthDays(r.regs[OFS_MONTH[5:0]], r.regs[OFS_YEAR[5:0]])) begin
              n.regs[OFS_DATE[5:0]] = BCD_ONE;
              n.regs[OFS_MONTH[5:0]] = bcdInc(r.regs[OFS_MONTH[5:0]], MONTH_LAST, BCD_ONE);
              if (r.regs[OFS_MONTH[5:0]] == MONTH_LAST) begin
                n.regs[OFS_YEAR[5:0]] = bcdInc(r.regs[OFS_YEAR[5:0]], YEAR_LAST, BCD_ZERO);
              end
            end else begin
              n.regs[OFS_DATE[5:0]] = bcdInc(r.regs[OFS_DATE[5:0]], 8'h31, BCD_ONE);
            end
          end
        end
      end
    end

    // daylight points checked as each new hour begins
    if (hourTurn && r.regs[OFS_DST_FWD_MONTH[5:0]][DST_ENABLE_BIT]) begin
      if (!r.regs[OFS_STATUS[5:0]][STATUS_DST_BIT] && dstMatch(n.regs, OFS_DST_FWD_MONTH)) begin
        n.regs[OFS_HOURS[5:0]] = bcdInc(n.regs[OFS_HOURS[5:0]], HOUR_LAST, BCD_ZERO);
        n.regs[OFS_STATUS[5:0]][STATUS_DST_BIT] = 1'b1;
      end else if (r.regs[OFS_STATUS[5:0]][STATUS_DST_BIT]
                   && dstMatch(n.regs, OFS_DST_REV_MONTH)) begin
        n.regs[OFS_HOURS[5:0]] = hourDec(n.regs[OFS_HOURS[5:0]]);
        n.regs[OFS_STATUS[5:0]][STATUS_DST_BIT] = 1'b0;
      end
    end

    // periodic compensation, interval chosen by supply and backup mode
    if (r.vddSync) begin
      bPeriod = COMP_PERIOD_S;
    end else begin
      case (r.regs[OFS_COMP_CONTROL_TRIM[5:0]][BMODE_HI:BMODE_LO])
        2'b01: bPeriod = BAT_PERIOD_1_S;
        2'b10: bPeriod = BAT_PERIOD_2_S;
        2'b11: bPeriod = BAT_PERIOD_3_S;
        default: bPeriod = 8'h00;
      endcase
    end
    if (!r.regs[OFS_COMP_CONTROL_TRIM[5:0]][TSE_BIT] || bPeriod == 8'h00) begin
      n.compSecs = 8'h00;
    end else if (secTick) begin
      if (r.compSecs + 8'h01 >= bPeriod) begin
        n.compSecs = 8'h00;
        compReq = 1'b1;
      end else begin
        n.compSecs = r.compSecs + 8'h01;
      end
    end

    // serial link, held idle and released on backup supply
    if (!r.vddSync) begin
      n.state = LINK_IDLE;
      n.drv.sdaOe = 1'b0;
    end else if (startSeen) begin
      n.state = DEV_ID;
      n.bitCnt = 4'h0;
      n.drv.sdaOe = 1'b0;
    end else if (stopSeen) begin
      n.state = LINK_IDLE;
      n.drv.sdaOe = 1'b0;
    end else if (sclRise) begin
      case (r.state)
        DEV_ID, WORD_ADDR, WR_DATA: begin
          n.shift = {r.shift[6:0], r.pinSync.sda};
          n.bitCnt = r.bitCnt + 4'h1;
        end
        RD_DATA: n.bitCnt = r.bitCnt + 4'h1;
        RD_ACK: n.masterAck = !r.pinSync.sda;
        default: n.state = r.state;
      endcase
    end else if (sclFall) begin
      case (r.state)
        DEV_ID: begin
          if (r.bitCnt == 4'h8) begin
            if (r.shift[7:1] == ID_RTC || r.shift[7:1] == ID_SRAM) begin
              n.useSram = r.shift[7:1] == ID_SRAM;
              n.shift[0] = r.shift[0];
              n.drv.sdaOe = 1'b1;
              n.state = DEV_ACK;
            end else begin
              n.state = WAIT_STOP;
            end
          end
        end
        DEV_ACK: begin
          n.bitCnt = 4'h0;
          if (r.shift[0]) begin
            n.txByte = r.useSram ? r.sram[r.ptr[6:0]] :
                       (r.ptr <= RTC_LAST_PTR ? r.regs[r.ptr[5:0]] : 8'h00);
            n.drv.sdaOe = !(r.useSram ? r.sram[r.ptr[6:0]][7] :
                            (r.ptr <= RTC_LAST_PTR && r.regs[r.ptr[5:0]][7]));
            n.state = RD_DATA;
          end else begin
            n.drv.sdaOe = 1'b0;
            n.state = WORD_ADDR;
          end
        end
        WORD_ADDR: begin
          if (r.bitCnt == 4'h8) begin
            n.ptr = r.useSram ? {1'b0, r.shift[6:0]} : r.shift;
            n.drv.sdaOe = 1'b1;
            n.state = ADDR_ACK;
          end
        end
        ADDR_ACK, WR_ACK: begin
          n.drv.sdaOe = 1'b0;
          n.bitCnt = 4'h0;
          n.state = WR_DATA;
        end
        WR_DATA: begin
          if (r.bitCnt == 4'h8) begin
            wrData = r.shift;
            if (r.useSram) begin
              n.sram[r.ptr[6:0]] = wrData;
            end else if (r.ptr == OFS_COMP_CONTROL_TRIM) begin
              n.regs[r.ptr[5:0]] = {wrData[7:5], r.regs[r.ptr[5:0]][TRIM_MSB:0]};
              compReq = compReq || wrData[TSE_BIT];
            end else if (r.ptr == OFS_DST_FWD_MONTH) begin
              n.regs[r.ptr[5:0]] = wrData;
              if (!wrData[DST_ENABLE_BIT]) begin
                n.regs[OFS_STATUS[5:0]][STATUS_DST_BIT] = 1'b0;
              end
            end else if (r.ptr <= RTC_LAST_PTR && r.ptr != OFS_INITIAL_TRIM
                         && r.ptr != OFS_CRYSTAL_COEF_COLD && r.ptr != OFS_STATUS
                         && r.ptr != OFS_ANALOG_TRIM_VALUE
                         && r.ptr != OFS_DIGITAL_TRIM_VALUE) begin
              n.regs[r.ptr[5:0]] = wrData;
            end
            n.ptr = nextPtr(r.ptr, r.useSram);
            n.drv.sdaOe = 1'b1;
            n.state = WR_ACK;
          end
        end
        RD_DATA: begin
          if (r.bitCnt == 4'h8) begin
            n.drv.sdaOe = 1'b0;
            n.ptr = nextPtr(r.ptr, r.useSram);
            n.state = RD_ACK;
          end else begin
            n.drv.sdaOe = !r.txByte[3'(4'h7 - r.bitCnt)];
          end
        end
        RD_ACK: begin
          n.bitCnt = 4'h0;
          if (r.masterAck) begin
            n.txByte = r.useSram ? r.sram[r.ptr[6:0]] : r.regs[r.ptr[5:0]];
            n.drv.sdaOe = !(r.useSram ? r.sram[r.ptr[6:0]][7] : r.regs[r.ptr[5:0]][7]);
            n.state = RD_DATA;
          end else begin
            n.drv.sdaOe = 1'b0;
            n.state = WAIT_STOP;
          end
        end
        default: n.drv.sdaOe = 1'b0;
      endcase
    end

    // compensation cycle, trims reloaded only when temperature moved
    if (compReq) begin
      n.compPulse = 1'b1;
      if (tempCode != r.lastTemp) begin
        n.lastTemp = tempCode;
        n.regs[OFS_ANALOG_TRIM_VALUE[5:0]] = {2'b00, tempCode[9:4]}
                                           ^ {3'b000, r.regs[OFS_COMP_CONTROL_TRIM[5:0]][4:0]};
        n.regs[OFS_DIGITAL_TRIM_VALUE[5:0]] = tempCode[7:0] - r.regs[OFS_INITIAL_TRIM[5:0]];
      end
    end

    // one-time recall of factory calibration after power-up
    if (!r.recallDone) begin
      n.recallDone = 1'b1;
      n.regs[OFS_INITIAL_TRIM[5:0]] = FACTORY_INITIAL_TRIM;
      n.regs[OFS_CRYSTAL_COEF_COLD[5:0]] = FACTORY_CRYSTAL_COEF;
      n.regs[OFS_COMP_CONTROL_TRIM[5:0]] = {3'b000, FACTORY_TRIM};
      n.regs[OFS_DATE[5:0]] = BCD_ONE;
      n.regs[OFS_MONTH[5:0]] = BCD_ONE;
      n.regs[OFS_STATUS[5:0]][STATUS_DST_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state flip-flops
  assign sdaDrv = r.drv;
  assign daylightForwardDone = r.regs[OFS_STATUS[5:0]][STATUS_DST_BIT];
  assign compCycle = r.compPulse;
endmodule : rtc_core

// *** verification/rtc_core_asserts.sv ***
// checker: link timing and output relations of the rtc core
module rtc_core_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkOsc,
  input wire rtc_pkg::i2cPins_t i2cIn,
  input wire logic vddPresent,
  input wire logic [9:0] tempCode,
  input wire rtc_pkg::sdaDrive_t sdaDrv,
  input wire logic daylightForwardDone,
  input wire logic compCycle
);
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // scl fell at the pin a few cycles ago and is still low
  sequence sclFellLately;
    !i2cIn.scl && ($past(i2cIn.scl, 3) || $past(i2cIn.scl, 4)
      || $past(i2cIn.scl, 5) || $past(i2cIn.scl, 6));
  endsequence
  // scl high with main supply for a whole window
  sequence sclHeld;
    (i2cIn.scl && vddPresent) [*8];
  endsequence
  // backup supply long enough to pass the synchroniser
  sequence onBackup;
    !vddPresent [*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_open_drain: assert property (!sdaDrv.sdaOut)
    else $error("sda driven high");
  a_backup_release: assert property (onBackup |-> !sdaDrv.sdaOe)
    else $error("sda pulled on backup supply");
  a_ack_needs_vdd: assert property ($rose(sdaDrv.sdaOe) |-> $past(vddPresent, 3))
    else $error("sda pulled without main supply");
  a_oe_after_fall: assert property ($rose(sdaDrv.sdaOe) |-> sclFellLately)
    else $error("sda pull not after scl fall");
  a_oe_steady_high: assert property (sclHeld |-> $stable(sdaDrv.sdaOe))
    else $error("sda drive moved while scl high");
  a_oe_holds: assert property ($rose(sdaDrv.sdaOe) && vddPresent |=> sdaDrv.sdaOe [*2])
    else $error("sda pull too short");
  a_comp_pulse: assert property (compCycle |=> !compCycle)
    else $error("compensation pulse too long");
  a_reset_quiet: assert property ($rose(rst_b) |-> !daylightForwardDone && !sdaDrv.sdaOe)
    else $error("outputs active after reset");
endmodule : rtc_core_asserts

// *** verification/i2c_master_model.sv ***
// partner model: serial bus master with pull-up released line
module i2c_master_model (
  input wire logic clk_sys,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;
  // idle bus, both lines released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // start or repeated start, sda falls while scl high
  task automatic start();
    sdaLow = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sdaLow = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(2);
  endtask : start
  // stop, sda rises while scl high
  task automatic stop();
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sdaLow = 1'b0;
    tick(8);
  endtask : stop
  // eight bits msb first plus the ninth bit; ack high when receiver pulled
  task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                      output logic ack);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, ackIn};
    for (int i = 8; i >= 0; i--) begin
      sdaLow = ~s[i];
      tick(6);
      scl = 1'b1;
      tick(4);
      r[i] = sdaLine;
      tick(4);
      scl = 1'b0;
      tick(2);
    end
    q = r[8:1];
    ack = ~r[0];
  endtask : xfer
endmodule : i2c_master_model

// *** verification/rtc_core_tb.sv ***
// testbench: reads, writes, compensation control and daylight saving of the rtc core
module rtc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_pkg::*;
  localparam logic [7:0] F_ITRIM = 8'h21;
  localparam logic [7:0] F_COEF = 8'h4a;
  localparam logic [4:0] F_TRIM = 5'h13;
  logic clk_sys = 1'b0, rst_b = 1'b0, clkOsc = 1'b0, vddPresent = 1'b1;
  logic mLow, scl, sdaLine, daylightForwardDone, compCycle;
  logic [9:0] tempCode = 10'h000;
  i2cPins_t i2cIn;
  sdaDrive_t sdaDrv;
  int num_errors = 0, cmp_count = 0, seed = 24307, compSeen = 0;
  int rtcM[48], sramM[128];
  logic [7:0] rdQ[$];
  ////////////////////////////////////////////////////////////////////////////////
  // clocks, wired-and bus, random temperature
  always #2 clk_sys = ~clk_sys;
  initial #0.7 forever #7.5 clkOsc = ~clkOsc;
  assign sdaLine = ~(mLow | sdaDrv.sdaOe);
  assign i2cIn = '{scl: scl, sda: sdaLine};
  always @(negedge clk_sys) tempCode <= 10'($random(seed));
  // pulse counted where it is settled, away from the launching edge
  always @(negedge clk_sys) if (compCycle === 1'b1) compSeen++;
  rtc_core #(.OSC_HZ(4), .FACTORY_INITIAL_TRIM(F_ITRIM), .FACTORY_CRYSTAL_COEF(F_COEF),
    .FACTORY_TRIM(F_TRIM)) u_rtc_core (.clk_sys(clk_sys), .rst_b(rst_b), .clkOsc(clkOsc),
    .i2cIn(i2cIn), .vddPresent(vddPresent), .tempCode(tempCode), .sdaDrv(sdaDrv),
    .daylightForwardDone(daylightForwardDone), .compCycle(compCycle));
  i2c_master_model u_i2c_master_model (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl),
    .sdaLow(mLow));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic sendB(input logic [7:0] d, input logic expAck);
    logic [7:0] q;
    logic a;
    u_i2c_master_model.xfer(d, 1'b1, q, a);
    chk(a === expAck, "acknowledge");
  endtask : sendB
  // write burst, model follows locked and read-only places
  task automatic wr(input logic [6:0] id, input logic [7:0] a, input logic [7:0] d[$]);
    int p;
    p = (id == ID_SRAM) ? a[6:0] : a;
    u_i2c_master_model.start();
    sendB({id, 1'b0}, 1'b1);
    sendB(a, 1'b1);
    foreach (d[i]) begin
      sendB(d[i], 1'b1);
      if (id == ID_SRAM) sramM[p] = d[i];
      else if (p == 13) rtcM[13] = (d[i] & 8'he0) | (rtcM[13] & 8'h1f);
      else if (p inside {0, 1, 2, 6, 7, 14, 15}) rtcM[p] = -1;
      else if (p != 11 && p != 12) rtcM[p] = d[i];
      p = (p + 1) % ((id == ID_SRAM) ? 128 : 48);
    end
    u_i2c_master_model.stop();
  endtask : wr
  // random read burst, last byte not acknowledged
  task automatic rd(input logic [6:0] id, input logic [7:0] a, input int n);
    logic [7:0] q;
    logic ak;
    int p;
    int m;
    p = (id == ID_SRAM) ? a[6:0] : a;
    rdQ.delete();
    u_i2c_master_model.start();
    sendB({id, 1'b0}, 1'b1);
    sendB(a, 1'b1);
    u_i2c_master_model.start();
    sendB({id, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_i2c_master_model.xfer(8'hff, i == n - 1, q, ak);
      m = (id == ID_SRAM) ? sramM[p] : rtcM[p];
      if (m >= 0) chk(q === m[7:0], "read data");
      if (i == n - 1) chk(ak === 1'b0, "line not released");
      rdQ.push_back(q);
      p = (p + 1) % ((id == ID_SRAM) ? 128 : 48);
    end
    // after the nack the device must not start the next byte
    repeat (4) @(negedge clk_sys);
    chk(sdaDrv.sdaOe === 1'b0, "data line held after nack");
    u_i2c_master_model.stop();
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [6:0] id;
    logic [7:0] dq[$];
    int c;
    int w;
    foreach (rtcM[i]) rtcM[i] = -1;
    foreach (sramM[i]) sramM[i] = -1;
    rtcM[3] = 1;
    rtcM[4] = 1;
    rtcM[11] = F_ITRIM;
    rtcM[12] = F_COEF;
    rtcM[13] = F_TRIM;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    repeat (8) @(negedge clk_sys);
    rd(ID_RTC, OFS_INITIAL_TRIM, 3);
    for (int i = 0; i < 6; i++) begin
      id = (i == 0) ? ID_RTC : (i == 1) ? ID_SRAM : 7'($random(seed));
      u_i2c_master_model.start();
      sendB({id, 1'b0}, id == ID_RTC || id == ID_SRAM);
      u_i2c_master_model.stop();
    end
    rd(ID_RTC, OFS_COMP_CONTROL_TRIM, 1);
    c = compSeen;
    wr(ID_RTC, OFS_COMP_CONTROL_TRIM, '{rdQ[0] & 8'h1f | 8'hc0});
    chk(compSeen > c, "no compensation on write");
    wr(ID_RTC, OFS_INITIAL_TRIM, '{8'h00, 8'hff, 8'h7f});
    rd(ID_RTC, OFS_INITIAL_TRIM, 3);
    wr(ID_RTC, OFS_COMP_CONTROL_TRIM, '{8'ha0});
    c = compSeen;
    repeat (1000) @(negedge clk_sys);
    chk(compSeen > c, "no periodic compensation");
    vddPresent = 1'b0;
    u_i2c_master_model.start();
    sendB({ID_RTC, 1'b0}, 1'b0);
    u_i2c_master_model.stop();
    c = compSeen;
    repeat (1000) @(negedge clk_sys);
    chk(compSeen > c, "no backup compensation");
    vddPresent = 1'b1;
    repeat (8) @(negedge clk_sys);
    // backup mode 120 s: one or two cycles in 200 s, never the 60 s count
    wr(ID_RTC, OFS_COMP_CONTROL_TRIM, '{8'hc0});
    vddPresent = 1'b0;
    c = compSeen;
    repeat (3000) @(negedge clk_sys);
    chk((compSeen - c) inside {1, 2}, "backup interval");
    vddPresent = 1'b1;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 4; i++) dq.push_back(8'($random(seed)));
    wr(ID_SRAM, 8'h7e, dq);
    rd(ID_SRAM, 8'h7e, 4);
    wr(ID_RTC, OFS_DST_FWD_MONTH, '{8'h84, 8'h05, 8'h05, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02});
    rd(ID_RTC, OFS_DST_FWD_MONTH, 8);
    wr(ID_RTC, OFS_SECONDS, '{8'h00, 8'h59, 8'h01, 8'h05, 8'h04});
    w = 0;
    while (daylightForwardDone !== 1'b1 && w < 3000) begin
      @(negedge clk_sys);
      w++;
    end
    chk(daylightForwardDone === 1'b1, "forward flag");
    rd(ID_RTC, OFS_HOURS, 1);
    chk(rdQ[0] === 8'h03, "forward hour");
    rd(ID_RTC, RTC_LAST_PTR, 6);
    wr(ID_RTC, OFS_DST_FWD_MONTH, '{8'h04});
    chk(daylightForwardDone === 1'b0, "flag kept on disable");
    complete_run();
  end
  // watchdog against a hung link
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule : rtc_core_tb
bind rtc_core rtc_core_asserts u_rtc_core_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
  .clkOsc(clkOsc), .i2cIn(i2cIn), .vddPresent(vddPresent), .tempCode(tempCode),
  .sdaDrv(sdaDrv), .daylightForwardDone(daylightForwardDone), .compCycle(compCycle));
